// File: logic/irq_out_pkg.sv
// Constants shared by the interrupt enable and output-signalling block.
package irq_out_pkg;
    // Register indexes; the byte address on the bus is four times the index.
    localparam logic [7:0] IDX_INT_EN = 8'h20;
    localparam logic [7:0] IDX_PIN_SEL = 8'h21;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h22;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h23;
    localparam logic [7:0] IDX_IRQ_CONFIG = 8'h24;
    // Field positions shared by enable, pin-select, status and mask registers.
    localparam int BIT_DATA_READY = 7;
    localparam int BIT_BUFFER = 6;
    localparam int BIT_OUTSIDE_BAND = 5;
    localparam int BIT_INSIDE_BAND = 4;
    localparam int BIT_ORIENTATION = 3;
    localparam int BIT_AUTO_SLEEP = 2;
    localparam int BIT_BOOT = 1;
    localparam int BIT_WAKE_OUT = 0;
    localparam int BIT_POLARITY = 0;
    // Reset values of the enable register for each strap level.
    localparam logic [7:0] INT_EN_RESET_GND = 8'h00;
    localparam logic [7:0] INT_EN_RESET_STRAP = 8'h20;
    localparam logic [7:0] PIN_SEL_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    // Timing.
    localparam int CLK_HZ = 10_000_000;
    localparam int MOTION_PULSE_MS = 5;
    localparam int BOOT_DONE_PULSE_MS = 1;
    localparam int BOOT_GND_PULSE_US = 1;
    localparam int MOTION_PULSE_CYCLES = MOTION_PULSE_MS * (CLK_HZ / 1000);
    localparam int BOOT_DONE_PULSE_CYCLES = BOOT_DONE_PULSE_MS * (CLK_HZ / 1000);
    localparam int BOOT_GND_PULSE_CYCLES = BOOT_GND_PULSE_US * (CLK_HZ / 1_000_000);
    localparam int PULSE_CNT_W = 20;
    // AHB encodings.
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'h0;
endpackage : irq_out_pkg

// File: logic/pulse_timer.sv
// Non-retriggerable one-shot that holds its output for a given number of cycles; a start while active is ignored.
`timescale 1ns/1ps
`default_nettype none
module pulse_timer #(
    parameter int CNT_W = 20
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Control
    input wire logic start,
    input wire logic abort,
    input wire logic [CNT_W-1:0] length,
    // Status
    output logic active
);
    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] count_nxt;

    // Abort wins over start so a pulse never begins in standby.
    always_comb begin
        count_nxt = count_r;
        if (abort) begin
            count_nxt = '0;
        end else if (start && count_r == '0) begin
            count_nxt = length;
        end else if (count_r != '0) begin
            count_nxt = count_r - 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end

    assign active = (count_r != '0);
endmodule : pulse_timer
`default_nettype wire

// File: logic/event_irq_enable_output.sv
// Interrupt enable, pin routing and interrupt pin signalling with an AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module event_irq_enable_output
    import irq_out_pkg::*;
#(
    parameter int MOTION_CYCLES = MOTION_PULSE_CYCLES,
    parameter int BOOT_DONE_CYCLES = BOOT_DONE_PULSE_CYCLES
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Strap and device state
    input wire logic boot_strap_select,
    input wire logic wake_mode,
    input wire logic standby,
    input wire logic output_data_rate_tick,
    // Event sources
    input wire logic data_ready_event,
    input wire logic output_reg_read,
    input wire logic buffer_flag,
    input wire logic outside_band_flag,
    input wire logic inside_band_flag,
    input wire logic orientation_flag,
    input wire logic auto_sleep_flag,
    input wire logic boot_done,
    // Interrupt pins
    output logic irq_pin_one_motion_out,
    output logic irq_pin_one_motion_oe_n,
    output logic irq_pin_two_boot_out,
    output logic irq_pin_two_boot_oe_n,
    output logic data_ready_flag,
    // Summary interrupt
    output logic irq
);
    localparam logic [PULSE_CNT_W-1:0] MOTION_LEN = PULSE_CNT_W'(MOTION_CYCLES);
    localparam logic [PULSE_CNT_W-1:0] BOOT2_LEN = PULSE_CNT_W'(BOOT_DONE_CYCLES);
    localparam logic [PULSE_CNT_W-1:0] BOOT1_LEN = PULSE_CNT_W'(BOOT_GND_PULSE_CYCLES);

    // Bus and register state.
    logic wr_pend_r, wr_pend_nxt;
    logic [7:0] wr_idx_r, wr_idx_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [7:0] int_en_r, int_en_nxt;
    logic [7:0] pin_sel_r, pin_sel_nxt;
    logic [7:0] status_r, status_nxt;
    logic [7:0] mask_r, mask_nxt;
    logic [7:0] config_r, config_nxt;
    logic init_r, init_nxt;
    logic strap_r, strap_nxt;
    logic drdy_r, drdy_nxt;
    logic [7:0] flags_prev_r, flags_prev_nxt;
    logic irq_r, irq_nxt;

    logic addr_ok;
    logic [7:0] addr_idx;
    logic accept;
    logic [7:0] flags;
    logic [7:0] enabled;
    logic [7:0] rise;
    logic motion_start;
    logic motion_active;
    logic boot_pulse_active;
    logic [PULSE_CNT_W-1:0] boot_len;
    logic pin_one_assert;
    logic pin_two_assert;
    logic boot_start;

    // SEQ is taken like NONSEQ; with no wait states a burst needs no special case.
    assign accept = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == 2'h3);
    assign addr_idx = haddr[9:2];
    // Only the lowest kilobyte decodes; anything above reads zero and drops writes.
    assign addr_ok = (haddr[31:10] == 22'h00_0000);

    // Flag vector laid out like the enable register; bit one is boot, bit zero wake.
    assign flags = {drdy_r, buffer_flag, outside_band_flag, inside_band_flag,
                    orientation_flag, auto_sleep_flag, boot_done, wake_mode};

    // Level events gated by their own bits.
    assign enabled = {flags[7:2] & int_en_r[7:2], 2'b00};

    always_comb begin
        wr_pend_nxt = 1'b0;
        wr_idx_nxt = wr_idx_r;
        rdata_nxt = rdata_r;
        int_en_nxt = int_en_r;
        pin_sel_nxt = pin_sel_r;
        mask_nxt = mask_r;
        config_nxt = config_r;
        status_nxt = status_r;
        init_nxt = 1'b1;
        strap_nxt = strap_r;
        // The strap is taken once after reset; a later change waits for the next reset.
        // Strap-dependent enable reset
        if (!init_r) begin
            strap_nxt = boot_strap_select;
            int_en_nxt = boot_strap_select ? INT_EN_RESET_STRAP : INT_EN_RESET_GND;
        end
        // Data phase of a write lands one cycle after its address phase.
        if (wr_pend_r) begin
            if (wr_idx_r == IDX_INT_EN) begin
                int_en_nxt = hwdata[7:0];
            end else if (wr_idx_r == IDX_PIN_SEL) begin
                pin_sel_nxt = hwdata[7:0];
            end else if (wr_idx_r == IDX_IRQ_MASK) begin
                mask_nxt = hwdata[7:0];
            end else if (wr_idx_r == IDX_IRQ_CONFIG) begin
                config_nxt = {7'h00, hwdata[BIT_POLARITY]};
            end
        end
        if (accept && hwrite) begin
            wr_pend_nxt = addr_ok;
            wr_idx_nxt = addr_idx;
        end
        // Read data is captured at the address phase so hrdata is a flip-flop.
        if (accept && !hwrite) begin
            rdata_nxt = 32'h0000_0000;
            if (!addr_ok) begin
                rdata_nxt = 32'h0000_0000;
            end else if (addr_idx == IDX_INT_EN) begin
                rdata_nxt = {24'h00_0000, int_en_r};
            end else if (addr_idx == IDX_PIN_SEL) begin
                rdata_nxt = {24'h00_0000, pin_sel_r};
            end else if (addr_idx == IDX_IRQ_STATUS) begin
                rdata_nxt = {24'h00_0000, status_r};
                status_nxt = 8'h00;
            end else if (addr_idx == IDX_IRQ_MASK) begin
                rdata_nxt = {24'h00_0000, mask_r};
            end else if (addr_idx == IDX_IRQ_CONFIG) begin
                rdata_nxt = {24'h00_0000, config_r};
            end
        end
        // New events are OR-ed in after the read clear, so a set wins.
        status_nxt = status_nxt | rise;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_idx_r <= 8'h00;
            rdata_r <= 32'h0000_0000;
            int_en_r <= INT_EN_RESET_GND;
            pin_sel_r <= PIN_SEL_RESET;
            status_r <= 8'h00;
            mask_r <= MASK_RESET;
            config_r <= CONFIG_RESET;
            init_r <= 1'b0;
            strap_r <= 1'b0;
        end else begin
            wr_pend_r <= wr_pend_nxt;
            wr_idx_r <= wr_idx_nxt;
            rdata_r <= rdata_nxt;
            int_en_r <= int_en_nxt;
            pin_sel_r <= pin_sel_nxt;
            status_r <= status_nxt;
            mask_r <= mask_nxt;
            config_r <= config_nxt;
            init_r <= init_nxt;
            strap_r <= strap_nxt;
        end
    end

    // Source flag tracking and the owned data-ready flag.
    always_comb begin
        drdy_nxt = drdy_r;
        if (output_reg_read) begin
            drdy_nxt = 1'b0;
        end
        if (data_ready_event) begin
            drdy_nxt = 1'b1;
        end
        flags_prev_nxt = flags;
        rise = flags & ~flags_prev_r;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            drdy_r <= 1'b0;
            flags_prev_r <= 8'h00;
        end else begin
            drdy_r <= drdy_nxt;
            flags_prev_r <= flags_prev_nxt;
        end
    end

    // A tick that lands while a pulse runs is dropped by the timer, so pulses never merge.
    // Repeat pulse each OUTPUT_DATA_RATE
    // Pin-two mapping makes the source unrouted in strap mode.
    assign motion_start = strap_r && output_data_rate_tick
                          && (|(enabled[7:2] & ~pin_sel_r[7:2]));

    // Self-timed pulse, ended at once by standby
    pulse_timer #(
        .CNT_W(PULSE_CNT_W)
    ) motion_pulse (
        .hclk(hclk),
        .hresetn(hresetn),
        .start(motion_start),
        .abort(standby),
        .length(MOTION_LEN),
        .active(motion_active)
    );

    // Boot pulse length depends on the strap; the short one covers the grounded mode.
    assign boot_len = strap_r ? BOOT2_LEN : BOOT1_LEN;

    // Boot pulse unless suppressed
    // The strap forces the boot pulse on whatever the suppress bit holds.
    assign boot_start = boot_done && (strap_r || !int_en_r[BIT_BOOT]);

    pulse_timer #(
        .CNT_W(PULSE_CNT_W)
    ) boot_pulse (
        .hclk(hclk),
        .hresetn(hresetn),
        .start(boot_start),
        .abort(1'b0),
        .length(boot_len),
        .active(boot_pulse_active)
    );

    // Wake level overrides on its pin
    always_comb begin
        // The two low bits carry the boot pulse and wake level instead of gated events.
        pin_one_assert = (|(enabled[7:2] & ~pin_sel_r[7:2]))
                         || (boot_pulse_active && !pin_sel_r[BIT_BOOT])
                         || (int_en_r[BIT_WAKE_OUT] && !pin_sel_r[BIT_WAKE_OUT] && wake_mode);
        pin_two_assert = (|(enabled[7:2] & pin_sel_r[7:2]))
                         || (boot_pulse_active && pin_sel_r[BIT_BOOT])
                         || (int_en_r[BIT_WAKE_OUT] && pin_sel_r[BIT_WAKE_OUT] && wake_mode);
        if (strap_r) begin
            irq_pin_one_motion_out = 1'b0;
            irq_pin_one_motion_oe_n = !motion_active;
            irq_pin_two_boot_out = 1'b0;
            irq_pin_two_boot_oe_n = !boot_pulse_active;
        end else begin
            // Grounded strap: push-pull with programmable polarity, always driven.
            irq_pin_one_motion_out = config_r[BIT_POLARITY] ? pin_one_assert : !pin_one_assert;
            irq_pin_one_motion_oe_n = 1'b0;
            irq_pin_two_boot_out = config_r[BIT_POLARITY] ? pin_two_assert : !pin_two_assert;
            irq_pin_two_boot_oe_n = 1'b0;
        end
    end

    // The summary interrupt leaves through a flip-flop; it is built from next-state values
    // so it still follows the status and mask registers without a cycle of lag.
    always_comb begin
        irq_nxt = |(status_nxt & mask_nxt);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= irq_nxt;
        end
    end

    assign data_ready_flag = drdy_r;
    assign irq = irq_r;
    assign hrdata = rdata_r;
    // Every transfer completes in a single data phase, so the slave never stretches the bus.
    assign hreadyout = 1'b1;
    assign hresp = HRESP_OKAY;
endmodule : event_irq_enable_output
`default_nettype wire

// File: test/event_irq_enable_output_chk.sv
// Concurrent checks on the interrupt pins and the data-ready flag.
`timescale 1ns/1ps
`default_nettype none
module event_irq_enable_output_chk #(
    parameter int MOTION_CYCLES = 20,
    parameter int BOOT_DONE_CYCLES = 10
) (
    // Clock, reset and device state
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic boot_strap_select,
    input wire logic standby,
    input wire logic output_data_rate_tick,
    input wire logic data_ready_event,
    input wire logic output_reg_read,
    // Pins and flag
    input wire logic irq_pin_one_motion_out,
    input wire logic irq_pin_one_motion_oe_n,
    input wire logic irq_pin_two_boot_out,
    input wire logic irq_pin_two_boot_oe_n,
    input wire logic data_ready_flag
);
    logic up_r;
    logic strap_up;
    int one_r;
    int one_nxt;
    int two_r;
    int two_nxt;
    // The strap is only taken one edge after reset, so counting waits for it.
    assign strap_up = up_r && boot_strap_select;
    always_comb begin
        one_nxt = (strap_up && !irq_pin_one_motion_oe_n) ? one_r + 1 : 0;
        two_nxt = (strap_up && !irq_pin_two_boot_oe_n) ? two_r + 1 : 0;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            up_r <= 1'b0;
            one_r <= 0;
            two_r <= 0;
        end else begin
            up_r <= 1'b1;
            one_r <= one_nxt;
            two_r <= two_nxt;
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_one_low; strap_up && !irq_pin_one_motion_oe_n |-> !irq_pin_one_motion_out; endproperty
    a_one_low: assert property (p_one_low) else $error("pin one driven high");
    property p_two_low; strap_up && !irq_pin_two_boot_oe_n |-> !irq_pin_two_boot_out; endproperty
    a_two_low: assert property (p_two_low) else $error("pin two driven high");
    property p_one_len;
        strap_up && $rose(irq_pin_one_motion_oe_n) && one_r != 0 && !$past(standby)
            |-> one_r == MOTION_CYCLES;
    endproperty
    a_one_len: assert property (p_one_len) else $error("pin one pulse length wrong");
    property p_two_len;
        strap_up && $rose(irq_pin_two_boot_oe_n) && two_r != 0 |-> two_r == BOOT_DONE_CYCLES;
    endproperty
    a_two_len: assert property (p_two_len) else $error("pin two pulse length wrong");
    property p_one_start; strap_up && $fell(irq_pin_one_motion_oe_n) |-> $past(output_data_rate_tick); endproperty
    a_one_start: assert property (p_one_start) else $error("pulse without rate tick");
    property p_drdy_set; data_ready_event |=> data_ready_flag; endproperty
    a_drdy_set: assert property (p_drdy_set) else $error("data-ready flag not set");
    property p_drdy_clr; data_ready_flag && output_reg_read && !data_ready_event |=> !data_ready_flag; endproperty
    a_drdy_clr: assert property (p_drdy_clr) else $error("read left flag set");
    property p_stby; strap_up && standby && !irq_pin_one_motion_oe_n |=> irq_pin_one_motion_oe_n; endproperty
    a_stby: assert property (p_stby) else $error("standby did not end pulse");
endmodule : event_irq_enable_output_chk
bind event_irq_enable_output event_irq_enable_output_chk #(.MOTION_CYCLES(MOTION_CYCLES),
    .BOOT_DONE_CYCLES(BOOT_DONE_CYCLES)) chk (.hclk(hclk), .hresetn(hresetn),
    .boot_strap_select(boot_strap_select), .standby(standby),
    .output_data_rate_tick(output_data_rate_tick), .data_ready_event(data_ready_event),
    .output_reg_read(output_reg_read), .irq_pin_one_motion_out(irq_pin_one_motion_out),
    .irq_pin_one_motion_oe_n(irq_pin_one_motion_oe_n), .irq_pin_two_boot_out(irq_pin_two_boot_out),
    .irq_pin_two_boot_oe_n(irq_pin_two_boot_oe_n), .data_ready_flag(data_ready_flag));
`default_nettype wire

// File: test/irq_host_model.sv
// Host side of the interrupt pins: pull-ups, pin levels and low-pulse timing.
`timescale 1ns/1ps
`default_nettype none
module irq_host_model (
    // Pins
    input wire logic hclk,
    input wire logic one_out,
    input wire logic one_oe_n,
    input wire logic two_out,
    input wire logic two_oe_n,
    // Observations
    output logic one_lvl,
    output logic two_lvl,
    output var int one_len,
    output var int two_len,
    output var int one_cnt,
    output var int two_cnt
);
    int run1 = 0;
    int run2 = 0;
    // A released pin is pulled up, never left floating.
    assign one_lvl = one_oe_n ? 1'b1 : one_out;
    assign two_lvl = two_oe_n ? 1'b1 : two_out;
    initial begin
        one_len = 0;
        two_len = 0;
        one_cnt = 0;
        two_cnt = 0;
    end
    always @(posedge hclk) begin
        run1 <= one_lvl ? 0 : run1 + 1;
        run2 <= two_lvl ? 0 : run2 + 1;
        if (one_lvl && run1 > 0) begin
            one_len <= run1;
            one_cnt <= one_cnt + 1;
        end
        if (two_lvl && run2 > 0) begin
            two_len <= run2;
            two_cnt <= two_cnt + 1;
        end
    end
endmodule : irq_host_model
`default_nettype wire

// File: test/event_irq_enable_output_tb_top.sv
// Self-checking bench for the interrupt enable and pin signalling block.
`timescale 1ns/1ps
`default_nettype none
module event_irq_enable_output_tb_top import irq_out_pkg::*;;
    localparam int MC = 20;
    localparam int BC = 10;
    logic hclk, hresetn, hsel, hwrite, strap, standby, wake, hreadyout, hresp;
    logic one_out, one_oe_n, two_out, two_oe_n, drdy, irq, lv1, lv2;
    logic [1:0] htrans;
    logic [3:0] pul;
    logic [7:0] flg;
    logic [31:0] haddr, hwdata, hrdata, rd, pins;
    int n1, n2, len1, len2, error_cnt, checks, cyc;
    assign pins = {28'h0000_000, irq, drdy, lv1, lv2};
    event_irq_enable_output #(.MOTION_CYCLES(MC), .BOOT_DONE_CYCLES(BC)) dut (.hclk(hclk),
        .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .boot_strap_select(strap), .wake_mode(wake),
        .standby(standby), .output_data_rate_tick(pul[0]), .data_ready_event(pul[1]),
        .output_reg_read(pul[2]), .buffer_flag(flg[6]), .outside_band_flag(flg[5]),
        .inside_band_flag(flg[4]), .orientation_flag(flg[3]), .auto_sleep_flag(flg[2]),
        .boot_done(pul[3]), .irq_pin_one_motion_out(one_out), .irq_pin_one_motion_oe_n(one_oe_n),
        .irq_pin_two_boot_out(two_out), .irq_pin_two_boot_oe_n(two_oe_n),
        .data_ready_flag(drdy), .irq(irq));
    irq_host_model host (.hclk(hclk), .one_out(one_out), .one_oe_n(one_oe_n), .two_out(two_out),
        .two_oe_n(two_oe_n), .one_lvl(lv1), .two_lvl(lv2), .one_len(len1), .two_len(len2),
        .one_cnt(n1), .two_cnt(n2));
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end
    task automatic report_and_stop();
        if (error_cnt == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Single word transfer; the global cycle limit ends a hung handshake.
    task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= {22'h00_0000, idx, 2'b00};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic rst(input logic s);
        @(posedge hclk);
        hresetn <= 1'b0;
        strap <= s;
        standby <= 1'b0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
    endtask : rst
    task automatic pulse(input logic [3:0] m);
        @(posedge hclk);
        pul <= m;
        @(posedge hclk);
        pul <= 4'h0;
    endtask : pulse
    task automatic setf(input logic [7:0] v);
        @(posedge hclk);
        flg <= v;
    endtask : setf
    task automatic settle(input int n);
        repeat (n) @(posedge hclk);
        @(negedge hclk);
    endtask : settle
    task automatic t_regs();
        rst(1'b0);
        bus(1'b0, IDX_INT_EN, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        bus(1'b1, IDX_INT_EN, 32'h0000_00a5);
        bus(1'b0, IDX_INT_EN, 32'h0000_0000);
        chk(rd, 32'h0000_00a5);
        chk(32'(hresp), 32'(HRESP_OKAY));
        bus(1'b0, 8'h30, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
    endtask : t_regs
    task automatic t_route();
        for (int i = 2; i < 7; i++) begin
            setf(8'(8'h01 << i));
            bus(1'b1, IDX_INT_EN, 32'h0000_0000);
            settle(1);
            chk(pins, 32'h0000_0003);
            bus(1'b1, IDX_INT_EN, 32'h0000_0001 << i);
            settle(1);
            chk(pins, 32'h0000_0001);
            bus(1'b1, IDX_PIN_SEL, 32'h0000_0001 << i);
            settle(1);
            chk(pins, 32'h0000_0002);
            bus(1'b1, IDX_PIN_SEL, 32'h0000_0000);
        end
    endtask : t_route
    task automatic t_drdy();
        setf(8'h00);
        bus(1'b1, IDX_INT_EN, 32'h0000_0080);
        pulse(4'h2);
        settle(1);
        chk(pins, 32'h0000_0005);
        pulse(4'h4);
        settle(1);
        chk(pins, 32'h0000_0003);
    endtask : t_drdy
    task automatic t_irq();
        bus(1'b0, IDX_IRQ_STATUS, 32'h0000_0000);
        bus(1'b1, IDX_IRQ_MASK, 32'h0000_0020);
        setf(8'h10);
        settle(2);
        chk(pins, 32'h0000_0003);
        setf(8'h30);
        settle(2);
        chk(pins, 32'h0000_000b);
        bus(1'b0, IDX_IRQ_STATUS, 32'h0000_0000);
        chk(rd, 32'h0000_0030);
        settle(1);
        chk(pins, 32'h0000_0003);
    endtask : t_irq
    task automatic t_boot();
        int a;
        a = n1;
        pulse(4'h8);
        settle(BOOT_GND_PULSE_CYCLES + 2);
        chk(n1, a + 1);
        chk(len1, BOOT_GND_PULSE_CYCLES);
        bus(1'b1, IDX_INT_EN, 32'h0000_0002);
        pulse(4'h8);
        settle(BOOT_GND_PULSE_CYCLES + 2);
        chk(n1, a + 1);
        bus(1'b1, IDX_INT_EN, 32'h0000_0001);
        @(posedge hclk);
        wake <= 1'b1;
        settle(1);
        chk(pins, 32'h0000_0001);
        bus(1'b1, IDX_IRQ_CONFIG, 32'h0000_0001);
        settle(1);
        chk(pins, 32'h0000_0002);
        @(posedge hclk);
        wake <= 1'b0;
        settle(1);
        chk(pins, 32'h0000_0000);
        bus(1'b1, IDX_IRQ_CONFIG, 32'h0000_0000);
        settle(1);
        chk(pins, 32'h0000_0003);
    endtask : t_boot
    task automatic t_strap();
        int a;
        int b;
        rst(1'b1);
        bus(1'b0, IDX_INT_EN, 32'h0000_0000);
        chk(rd, 32'h0000_0020);
        setf(8'h20);
        a = n1;
        b = n2;
        pulse(4'h1);
        settle(MC + 2);
        chk(n1, a + 1);
        chk(len1, MC);
        pulse(4'h1);
        settle(MC + 2);
        chk(n1, a + 2);
        pulse(4'h8);
        settle(BC + 4);
        chk(n2, b + 1);
        chk(len2, BC);
        bus(1'b1, IDX_PIN_SEL, 32'h0000_0020);
        pulse(4'h1);
        settle(MC + 2);
        chk({n1[15:0], n2[15:0]}, {16'(a + 2), 16'(b + 1)});
        setf(8'h00);
        bus(1'b1, IDX_PIN_SEL, 32'h0000_0000);
        bus(1'b1, IDX_INT_EN, 32'h0000_0080);
        pulse(4'h2);
        pulse(4'h1);
        settle(2);
        chk(pins, 32'h0000_0005);
        pulse(4'h4);
        settle(1);
        chk(pins, 32'h0000_0001);
        @(posedge hclk);
        standby <= 1'b1;
        settle(1);
        chk(pins, 32'h0000_0003);
    endtask : t_strap
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        htrans = 2'h0;
        hwrite = 1'b0;
        haddr = 32'h0000_0000;
        hwdata = 32'h0000_0000;
        strap = 1'b0;
        standby = 1'b0;
        wake = 1'b0;
        pul = 4'h0;
        flg = 8'h00;
        error_cnt = 0;
        checks = 0;
        cyc = 0;
        t_regs();
        t_route();
        t_drdy();
        t_irq();
        t_boot();
        t_strap();
        report_and_stop();
    end
endmodule : event_irq_enable_output_tb_top
`default_nettype wire
